//--- clkrst_pkg.sv
/*
 Package for the clock and reset sequencer: divider codes, reset
 pulse lengths, lock and boot-sampling counts.
 Assumes CLOCK is the oscillator clock at 200 MHz.
*/
package clkrst_pkg;
   // ----------------------------------------------------------
   // Clock rates and times
   // ----------------------------------------------------------
   localparam int unsigned CLOCK_MHZ = 200;
   localparam int unsigned POR_PULSE_US = 600;
   localparam int unsigned POR_PULSE_CYC = POR_PULSE_US * CLOCK_MHZ;
   localparam int unsigned WD_PULSE_CYC = 512;
   localparam int unsigned WARM_MIN_CYC = 32;
   localparam int unsigned BUS_VALID_CYC = 32;
   localparam int unsigned BOOT_HOLD_CYC = 1000;
   localparam int unsigned LOCK_MIN_CYC = 10000;
   // ----------------------------------------------------------
   // Divider codes and reset values
   // ----------------------------------------------------------
   localparam logic [1:0] SYSCLK_DIVIDE_SELECT_QUARTER = 2'h0;
   localparam logic [1:0] SYSCLK_DIVIDE_SELECT_HALF = 2'h2;
   localparam logic [1:0] SYSCLK_DIVIDE_SELECT_ONE = 2'h3;
   localparam logic [1:0] CLKOUT_DIV4 = 2'h0;
   localparam logic [1:0] CLKOUT_DIV2 = 2'h1;
   localparam logic [1:0] CLKOUT_DIV1 = 2'h2;
   localparam logic [1:0] CLKOUT_OFF = 2'h3;
   localparam logic [3:0] PLL_MULT_RESET = 4'h0;
   localparam logic [15:0] LOCK_PRD_RESET = 16'hFFFF;
   localparam int unsigned CNT_W = 17;
   localparam int unsigned DIV_W = 6;

   typedef enum logic [2:0] {
      ST_POR, ST_RESET, ST_RELEASE, ST_BOOT, ST_RUN, ST_LOCK
   } seq_state_t;
endpackage : clkrst_pkg

//--- clock_reset_sequencer.sv
/*
 Clock and reset sequencer: makes the system and external clock
 enables from the oscillator clock, runs the PLL lock phase, drives
 and accepts the reset pin, samples boot straps and flags bus valid.
 Assumes CLOCK is the oscillator clock; pins pass a 2-FF synchroniser.
*/
// Notes on behaviour
// - Power-up system clock is oscillator divided by four
// - Clock-out divider resets to divide-by-four
// - Boot sets divide-by-one; clock-out becomes osc/4
// - Clock-out pin off until software enables it
// - Sample boot pins after reset, then branch
// - Device-driven power-on reset pulse at most 600us
// - Watchdog reset pulse at most 512 cycles
// - Bus valid within 32 cycles of release
// - Internal power-on reset needs no external reset
// - PLL write starts lock; system clock osc/2
// - After lock, clock is osc times mult over two; code applies mult only at half select: osc/2 for zero, else osc
// - Lock length counted from lock period value
`timescale 1ns/100ps
module clock_reset_sequencer
   import clkrst_pkg::*;
#(
   parameter int unsigned POR_CYCLES = POR_PULSE_CYC
) (
   input wire logic CLOCK,
   input wire logic RSTN,
   input wire logic RESET_PIN_N_IN,
   output logic RESET_PIN_N_OUT,
   output logic RESET_PIN_N_OE_N,
   input wire logic WATCHDOG_RESET,
   input wire logic [1:0] BOOT_MODE_PINS,
   input wire logic [1:0] SYSCLK_DIVIDE_SELECT,
   input wire logic [1:0] CLKOUT_DIVIDER_FIELD,
   input wire logic CLKOUT_PIN_ENABLE,
   input wire logic [3:0] PLL_MULTIPLIER_CONTROL,
   input wire logic PLL_MULT_WRITE,
   input wire logic [15:0] PLL_LOCK_PERIOD,
   output logic SYSTEM_CLOCK_OUT,
   output logic EXTERNAL_CLOCK_OUT,
   output logic EXTERNAL_CLOCK_OUT_OE_N,
   output logic CORE_RESET_N,
   output logic BUS_VALID,
   output logic [1:0] BOOT_MODE_LATCHED,
   output logic BOOT_DONE,
   output logic PLL_LOCKING,
   output logic [1:0] EFFECTIVE_SYSCLK_DIVIDE_SELECT
);
   // ----------------------------------------------------------
   // State
   // ----------------------------------------------------------
   typedef struct packed {
      // Pin synchronisers, two stages each
      logic [1:0] rst_sync;
      logic [1:0] wd_sync;
      logic [1:0] boot_s0;
      logic [1:0] boot_s1;
      // Sequencer
      seq_state_t st;
      logic [CNT_W-1:0] cnt;
      logic [15:0] lock_cnt;
      logic locking;
      logic wd_pulse;
      // Clock dividers
      logic [DIV_W-1:0] sys_div;
      logic [DIV_W-1:0] ext_div;
      logic [1:0] sysclk_divide_select;
      logic [1:0] clkout_div;
      logic [3:0] mult;
      logic sysclk;
      logic extclk;
      logic ext_oe_n;
      // Reset pin and core side
      logic pin_out;
      logic pin_oe_n;
      logic core_rst_n;
      logic bus_valid;
      logic [1:0] boot_mode;
      logic boot_done;
   } state_t;

   state_t q, d;

   // System clock period in oscillator cycles and its one-cycle tick
   logic [DIV_W-1:0] sys_per;
   logic sys_tick;

   // System clock period in oscillator cycles, from sysclk_divide_select.
   // While locking the PLL is bypassed, so the multiplier is ignored.
   // A multiplied clock above CLOCK cannot be shown; it runs at one cycle.
   function automatic logic [DIV_W-1:0] sys_period(input logic [1:0] sel, input logic lock,
                                                 input logic [3:0] mult);
      logic [DIV_W-1:0] per;
      per = 6'h2;
      if (!lock) begin
         unique case (sel)
            SYSCLK_DIVIDE_SELECT_QUARTER: per = 6'h4;
            SYSCLK_DIVIDE_SELECT_HALF: per = (mult == 4'h0) ? 6'h2 : 6'h1;
            SYSCLK_DIVIDE_SELECT_ONE: per = 6'h1;
            default: per = 6'h2;
         endcase
      end
      return per;
   endfunction : sys_period

   // Half period of the clock-out pin in system clock ticks
   function automatic logic [DIV_W-1:0] ext_half(input logic [1:0] sel);
      logic [DIV_W-1:0] h;
      unique case (sel)
         CLKOUT_DIV4: h = 6'h2;
         CLKOUT_DIV2: h = 6'h1;
         default: h = 6'h1;
      endcase
      return h;
   endfunction : ext_half

   always_comb begin
      d = q;
      sys_per = 6'h1;
      sys_tick = 1'b0;
      d.rst_sync = {q.rst_sync[0], RESET_PIN_N_IN};
      d.wd_sync = {q.wd_sync[0], WATCHDOG_RESET};
      d.boot_s0 = BOOT_MODE_PINS;
      d.boot_s1 = q.boot_s0;
      d.cnt = q.cnt + 17'h1;

      // ----------------------------------------------------------
      // Reset sequencing
      // ----------------------------------------------------------
      unique case (q.st)
         ST_POR: begin
            // Own pulse so reset is clean with the pin left open.
            d.pin_out = 1'b0;
            d.pin_oe_n = 1'b0;
            if (q.cnt >= CNT_W'(POR_CYCLES - 1)) begin
               d.pin_oe_n = 1'b1;
               d.st = ST_RESET;
               d.cnt = '0;
            end
         end
         ST_RESET: begin
            // Any reset drops the clock-out drive and the PLL back to bypass
            d.core_rst_n = 1'b0;
            d.bus_valid = 1'b0;
            d.boot_done = 1'b0;
            d.ext_oe_n = 1'b1;
            d.locking = 1'b0;
            d.mult = PLL_MULT_RESET;
            if (q.wd_pulse) begin
               if (q.cnt >= CNT_W'(WD_PULSE_CYC - 1)) begin
                  d.wd_pulse = 1'b0;
                  d.pin_oe_n = 1'b1;
                  d.cnt = '0;
               end
            end else if (!q.rst_sync[1]) begin
               d.cnt = '0;
            end else begin
               // Released pin seen only through synchroniser.
               d.st = ST_RELEASE;
               d.cnt = '0;
            end
         end
         ST_RELEASE: begin
            d.core_rst_n = 1'b1;
            d.sysclk_divide_select = SYSCLK_DIVIDE_SELECT_QUARTER;
            d.clkout_div = CLKOUT_DIV4;
            d.ext_oe_n = 1'b1;
            if (q.cnt >= CNT_W'(BUS_VALID_CYC - 4)) begin
               d.bus_valid = 1'b1;
               d.st = ST_BOOT;
               d.cnt = '0;
            end
         end
         ST_BOOT: begin
            // Straps are held stable by the board for this window.
            if (q.cnt >= CNT_W'(BOOT_HOLD_CYC * 4 - 1)) begin
               d.boot_mode = q.boot_s1;
               d.boot_done = 1'b1;
               d.sysclk_divide_select = SYSCLK_DIVIDE_SELECT_ONE;
               d.st = ST_RUN;
            end
         end
         ST_RUN: begin
            d.sysclk_divide_select = SYSCLK_DIVIDE_SELECT;
            d.clkout_div = CLKOUT_DIVIDER_FIELD;
            d.ext_oe_n = !(CLKOUT_PIN_ENABLE && CLKOUT_DIVIDER_FIELD != CLKOUT_OFF);
            if (PLL_MULT_WRITE) begin
               d.mult = PLL_MULTIPLIER_CONTROL;
               d.locking = 1'b1;
               d.lock_cnt = PLL_LOCK_PERIOD;
               d.st = ST_LOCK;
            end
         end
         ST_LOCK: begin
            d.lock_cnt = q.lock_cnt - 16'h1;
            if (q.lock_cnt <= 16'h1) begin
               d.locking = 1'b0;
               d.st = ST_RUN;
            end
         end
         default: d.st = ST_POR;
      endcase

      // Watchdog overrides any running state; pin pulled for the pulse.
      if (q.wd_sync[1] && q.st != ST_POR && !q.wd_pulse) begin
         d.st = ST_RESET;
         d.wd_pulse = 1'b1;
         d.pin_out = 1'b0;
         d.pin_oe_n = 1'b0;
         d.cnt = '0;
         d.core_rst_n = 1'b0;
         d.bus_valid = 1'b0;
      end else if (!q.rst_sync[1] && q.st != ST_POR && q.st != ST_RESET) begin
         d.st = ST_RESET;
         d.cnt = '0;
         d.core_rst_n = 1'b0;
         d.bus_valid = 1'b0;
      end

      // ----------------------------------------------------------
      // Clock dividers
      // ----------------------------------------------------------
      // Locking forces osc/2; after lock only the half select uses mult: osc/2 at zero, else osc.
      // The clock-out divider counts system ticks, not pin edges, so a
      // one-cycle system clock still divides correctly. Limitation: the
      // pin shows any system clock of one cycle as a CLOCK/2 toggle.
      sys_per = sys_period(q.sysclk_divide_select, q.locking, q.mult);
      if (q.sys_div + 6'h1 >= sys_per) begin
         d.sys_div = '0;
      end else begin
         d.sys_div = q.sys_div + 6'h1;
      end
      if (d.sys_div == '0 || d.sys_div == (sys_per >> 1)) begin
         d.sysclk = !q.sysclk;
      end
      sys_tick = (d.sys_div == '0);
      if (sys_tick) begin
         d.ext_div = q.ext_div + 6'h1;
         if (q.ext_div + 6'h1 >= ext_half(q.clkout_div)) begin
            d.ext_div = '0;
            d.extclk = !q.extclk;
         end
      end
   end

   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         q <= '{rst_sync: 2'h0, wd_sync: 2'h0, boot_s0: 2'h0, boot_s1: 2'h0,
                st: ST_POR, cnt: '0, lock_cnt: LOCK_PRD_RESET, locking: 1'b0,
                wd_pulse: 1'b0, sys_div: '0, ext_div: '0, sysclk_divide_select: SYSCLK_DIVIDE_SELECT_QUARTER,
                clkout_div: CLKOUT_DIV4, mult: PLL_MULT_RESET, sysclk: 1'b0,
                extclk: 1'b0, ext_oe_n: 1'b1, pin_out: 1'b0, pin_oe_n: 1'b0,
                core_rst_n: 1'b0, bus_valid: 1'b0, boot_mode: 2'h0,
                boot_done: 1'b0};
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------
   assign RESET_PIN_N_OUT = q.pin_out;
   assign RESET_PIN_N_OE_N = q.pin_oe_n;
   assign SYSTEM_CLOCK_OUT = q.sysclk;
   assign EXTERNAL_CLOCK_OUT = q.extclk;
   assign EXTERNAL_CLOCK_OUT_OE_N = q.ext_oe_n;
   assign CORE_RESET_N = q.core_rst_n;
   assign BUS_VALID = q.bus_valid;
   assign BOOT_MODE_LATCHED = q.boot_mode;
   assign BOOT_DONE = q.boot_done;
   assign PLL_LOCKING = q.locking;
   assign EFFECTIVE_SYSCLK_DIVIDE_SELECT = q.sysclk_divide_select;
endmodule : clock_reset_sequencer

//--- clock_reset_sequencer_chk.sv
/*
 Port checker for the clock and reset sequencer.
 Assumes CLOCK is the oscillator clock and RSTN the power-on reset.
*/
`timescale 1ns/100ps
module clock_reset_sequencer_chk
   import clkrst_pkg::*;
#(
   parameter int unsigned POR_CYCLES = POR_PULSE_CYC
) (
   input wire logic CLOCK,
   input wire logic RSTN,
   input wire logic RESET_PIN_N_IN,
   input wire logic RESET_PIN_N_OE_N,
   input wire logic WATCHDOG_RESET,
   input wire logic [1:0] BOOT_MODE_PINS,
   input wire logic CLKOUT_PIN_ENABLE,
   input wire logic PLL_MULT_WRITE,
   input wire logic [15:0] PLL_LOCK_PERIOD,
   input wire logic SYSTEM_CLOCK_OUT,
   input wire logic EXTERNAL_CLOCK_OUT_OE_N,
   input wire logic CORE_RESET_N,
   input wire logic BUS_VALID,
   input wire logic [1:0] BOOT_MODE_LATCHED,
   input wire logic BOOT_DONE,
   input wire logic PLL_LOCKING,
   input wire logic [1:0] EFFECTIVE_SYSCLK_DIVIDE_SELECT
);
   // ------------------------------------------------------------
   // Helper counters
   // ------------------------------------------------------------
   localparam int unsigned PULSE_MAX = (POR_CYCLES > 512) ? POR_CYCLES : 512;
   logic [16:0] oe_cnt_q;
   logic [16:0] lock_cnt_q;
   logic [15:0] per_q;
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RSTN);
   sequence accept_s;
      PLL_MULT_WRITE && BOOT_DONE && CORE_RESET_N && !PLL_LOCKING;
   endsequence
   sequence held_s;
      !CORE_RESET_N [*2];
   endsequence
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         oe_cnt_q <= 17'h0;
         lock_cnt_q <= 17'h0;
         per_q <= 16'h0;
      end else begin
         oe_cnt_q <= RESET_PIN_N_OE_N ? 17'h0 : oe_cnt_q + 17'h1;
         lock_cnt_q <= PLL_LOCKING ? lock_cnt_q + 17'h1 : 17'h0;
         // Period is latched only on an accepted write, as the device does
         if (PLL_MULT_WRITE && BOOT_DONE && CORE_RESET_N && !PLL_LOCKING) begin
            per_q <= PLL_LOCK_PERIOD;
         end
      end
   end
   pulse_len_a: assert property (oe_cnt_q <= PULSE_MAX)
      else $error("reset pulse too long");
   wd_pull_a: assert property ($rose(WATCHDOG_RESET) && CORE_RESET_N |-> ##[1:4] !RESET_PIN_N_OE_N)
      else $error("watchdog did not pull pin");
   warm_enter_a: assert property ($fell(RESET_PIN_N_IN) |-> ##[0:3] !CORE_RESET_N)
      else $error("pin reset not taken");
   sync_hold_a: assert property ($rose(RESET_PIN_N_IN) |-> held_s)
      else $error("release not synchronised");
   bus_valid_a: assert property ($rose(RESET_PIN_N_IN) |-> ##[1:32] BUS_VALID)
      else $error("bus valid late");
   quarter_div_a: assert property (CORE_RESET_N && !BOOT_DONE |-> EFFECTIVE_SYSCLK_DIVIDE_SELECT == SYSCLK_DIVIDE_SELECT_QUARTER)
      else $error("power-up divider wrong");
   clkout_off_a: assert property (!CLKOUT_PIN_ENABLE [*2] |-> EXTERNAL_CLOCK_OUT_OE_N)
      else $error("clock-out driven unasked");
   lock_start_a: assert property (accept_s |=> PLL_LOCKING)
      else $error("lock phase not started");
   lock_toggle_a: assert property (PLL_LOCKING [*2] |-> $changed(SYSTEM_CLOCK_OUT))
      else $error("lock clock not half rate");
   lock_len_a: assert property ($fell(PLL_LOCKING) |->
      lock_cnt_q == ((per_q == 16'h0) ? 17'h1 : {1'b0, per_q}))
      else $error("lock length wrong");
   boot_latch_a: assert property ($rose(BOOT_DONE) |-> BOOT_MODE_LATCHED == BOOT_MODE_PINS)
      else $error("straps latched wrong");
endmodule : clock_reset_sequencer_chk

bind clock_reset_sequencer clock_reset_sequencer_chk #(.POR_CYCLES(POR_CYCLES)) u_chk (
   .CLOCK(CLOCK), .RSTN(RSTN), .RESET_PIN_N_IN(RESET_PIN_N_IN),
   .RESET_PIN_N_OE_N(RESET_PIN_N_OE_N), .WATCHDOG_RESET(WATCHDOG_RESET),
   .BOOT_MODE_PINS(BOOT_MODE_PINS), .CLKOUT_PIN_ENABLE(CLKOUT_PIN_ENABLE),
   .PLL_MULT_WRITE(PLL_MULT_WRITE), .PLL_LOCK_PERIOD(PLL_LOCK_PERIOD),
   .SYSTEM_CLOCK_OUT(SYSTEM_CLOCK_OUT), .EXTERNAL_CLOCK_OUT_OE_N(EXTERNAL_CLOCK_OUT_OE_N),
   .CORE_RESET_N(CORE_RESET_N), .BUS_VALID(BUS_VALID), .BOOT_MODE_LATCHED(BOOT_MODE_LATCHED),
   .BOOT_DONE(BOOT_DONE), .PLL_LOCKING(PLL_LOCKING), .EFFECTIVE_SYSCLK_DIVIDE_SELECT(EFFECTIVE_SYSCLK_DIVIDE_SELECT));

//--- board_reset_model.sv
/*
 Board side of the reset pin and the boot straps.
 Assumes a pull-up on the reset net; the device pulls it when its enable is low.
*/
`timescale 1ns/100ps
module board_reset_model (
   input wire logic clock,
   input wire logic pin_oe_n,
   output logic pin_level,
   output logic [1:0] straps
);
   logic pull_q = 1'b0;
   initial straps = 2'h2;
   // Wired-AND with pull-up: no board pull needed for power-up
   assign pin_level = !(pull_q || !pin_oe_n);
   task automatic warm_reset(input int cycles);
      @(posedge clock);
      #1;
      pull_q = 1'b1;
      repeat (cycles) @(posedge clock);
      #1;
      pull_q = 1'b0;
   endtask : warm_reset
   // Straps only move just before a reset, then stay put
   task automatic set_straps(input logic [1:0] value);
      straps = value;
   endtask : set_straps
endmodule : board_reset_model

//--- clock_reset_sequencer_tb.sv
/*
 Testbench: power-up, boot, PLL lock, warm and watchdog resets.
 Assumes the board model on the reset pin and straps.
*/
`timescale 1ns/100ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
   $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module clock_reset_sequencer_tb;
   import clkrst_pkg::*;
   int miscompares = 0;
   int samples_checked = 0;
   int n;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic wd_req = 1'b0;
   logic pll_wr = 1'b0;
   logic clk_en = 1'b0;
   logic [3:0] mult = 4'h4;
   logic [15:0] lock_per = 16'h14;
   logic pin_in, pin_out, pin_oe_n, sys_clk, ext_clk, ext_oe_n;
   logic core_rst_n, bus_ok, boot_done, locking;
   logic [1:0] straps, boot_latched, eff_div;
   always #2.5 clock = ~clock;
   board_reset_model u_board_reset_model (.clock(clock), .pin_oe_n(pin_oe_n),
      .pin_level(pin_in), .straps(straps));
   clock_reset_sequencer #(.POR_CYCLES(50)) u_clock_reset_sequencer (.CLOCK(clock),
      .RSTN(rstn), .RESET_PIN_N_IN(pin_in), .RESET_PIN_N_OUT(pin_out),
      .RESET_PIN_N_OE_N(pin_oe_n), .WATCHDOG_RESET(wd_req), .BOOT_MODE_PINS(straps),
      .SYSCLK_DIVIDE_SELECT(SYSCLK_DIVIDE_SELECT_ONE), .CLKOUT_DIVIDER_FIELD(CLKOUT_DIV4),
      .CLKOUT_PIN_ENABLE(clk_en), .PLL_MULTIPLIER_CONTROL(mult), .PLL_MULT_WRITE(pll_wr),
      .PLL_LOCK_PERIOD(lock_per), .SYSTEM_CLOCK_OUT(sys_clk), .EXTERNAL_CLOCK_OUT(ext_clk),
      .EXTERNAL_CLOCK_OUT_OE_N(ext_oe_n), .CORE_RESET_N(core_rst_n), .BUS_VALID(bus_ok),
      .BOOT_MODE_LATCHED(boot_latched), .BOOT_DONE(boot_done), .PLL_LOCKING(locking),
      .EFFECTIVE_SYSCLK_DIVIDE_SELECT(eff_div));
   task automatic step(input int k);
      repeat (k) @(posedge clock);
      #1;
   endtask : step
   // Edges between two rising edges of the chosen clock
   task automatic period(input bit ext, output int p);
      logic c;
      logic q;
      q = 1'b1;
      p = -1;
      for (int k = 0; k < 100; k++) begin
         step(1);
         c = ext ? ext_clk : sys_clk;
         if (p >= 0) p++;
         if (c === 1'b1 && q === 1'b0) begin
            if (p > 0) break;
            p = 0;
         end
         q = c;
      end
   endtask : period
   task automatic pll(input logic [3:0] m, input logic [15:0] per);
      int len;
      mult = m;
      lock_per = per;
      pll_wr = 1'b1;
      step(1);
      pll_wr = 1'b0;
      lock_per = 16'h64;
      `CHK("locking", 1'b1, locking)
      // A second write mid-lock must be ignored
      for (len = 0; locking === 1'b1 && len < 300; len++) begin
         pll_wr = (len == 2);
         step(1);
      end
      pll_wr = 1'b0;
      `CHK("lock_len", (per == 16'h0) ? 1 : int'(per), len)
      step(2);
   endtask : pll
   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_sim
   initial begin
      #100000;
      miscompares++;
      end_sim;
   end
   initial begin
      step(3);
      rstn = 1'b1;
      `CHK("pin_pull", 1'b0, pin_in)
      `CHK("pin_drive", 1'b0, pin_out)
      for (n = 0; n < 200 && core_rst_n !== 1'b1; n++) step(1);
      `CHK("core_out", 1'b1, core_rst_n)
      period(1'b0, n);
      `CHK("sys_div4", 4, n)
      period(1'b1, n);
      `CHK("ext_div16", 16, n)
      `CHK("ext_off", 1'b1, ext_oe_n)
      for (n = 0; n < 5000 && boot_done !== 1'b1; n++) step(1);
      `CHK("boot_a", 2'h2, boot_latched)
      period(1'b1, n);
      `CHK("ext_div4", 4, n)
      clk_en = 1'b1;
      step(2);
      `CHK("ext_on", 1'b0, ext_oe_n)
      pll(4'h4, 16'h14);
      pll(4'h8, 16'h0);
      period(1'b0, n);
      `CHK("sys_run", 2, n)
      u_board_reset_model.set_straps(2'h1);
      u_board_reset_model.warm_reset(40);
      `CHK("warm_core", 1'b0, core_rst_n)
      for (n = 0; n < 32 && bus_ok !== 1'b1; n++) step(1);
      `CHK("bus_valid", 1'b1, bus_ok)
      for (n = 0; n < 5000 && boot_done !== 1'b1; n++) step(1);
      `CHK("boot_b", 2'h1, boot_latched)
      wd_req = 1'b1;
      step(3);
      wd_req = 1'b0;
      for (n = 0; n < 10 && pin_oe_n !== 1'b0; n++) step(1);
      for (n = 0; n < 600 && pin_oe_n === 1'b0; n++) step(1);
      `CHK("wd_pulse", 1'b1, (n > 0 && n <= 512))
      end_sim;
   end
endmodule : clock_reset_sequencer_tb
